//--- bench/eeps_bench.sv
// self-checking bench: master and eeprom ends joined on one link
// assumes shortened write cycle and quarter to keep the run brief
`timescale 1ns/1ns
module eeps_bench;
  // long enough that a poll's control byte lands inside the write cycle
  localparam int TWC = 1000;
  localparam int LIMIT = 80000;
  logic sys_clk, sys_rst, write_protect, busy, busy_seen;
  logic cmd_valid, cmd_ready, cmd_read, cmd_poll, done, nacked;
  logic wr_valid, wr_ready, rd_valid;
  logic [2:0] cmd_dev, cs;
  logic [13:0] cmd_addr, addr;
  logic [7:0] cmd_len, wr_data, rd_data;
  logic [7:0] ref_mem [0:16383];
  logic [7:0] pg [0:65];
  logic [7:0] exp_rd [$];
  logic exp_nk [$];
  int err_count, samples_checked, cycles, seed;
  eeps_if bus_if();
  eeps_slave #(.TWC_CYC(TWC)) u_eeps_slave (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .chip_select_bit_two(cs[2]),
    .chip_select_bit_one(cs[1]), .chip_select_bit_zero(cs[0]),
    .write_protect(write_protect), .busy(busy), .bus(bus_if));
  eeps_master #(.QTR_CYC(8)) u_eeps_master (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_poll(cmd_poll), .cmd_dev(cmd_dev),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nacked(nacked), .bus(bus_if));
  eeps_properties #(.TWC_CYC(TWC)) u_eeps_properties (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe), .busy(busy));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1)
      busy_seen <= 1'b1;
    if (cycles == LIMIT) begin
      err_count++;
      stop_test();
    end
  end
  // results are matched in order, so one queue per result kind suffices
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1)
      check("rd_data", exp_rd.size() ? exp_rd.pop_front() : 8'hxx,
            rd_data);
    if (done === 1'b1)
      check("nacked",
            exp_nk.size() ? {7'h0, exp_nk.pop_front()} : 8'hxx,
            {7'h0, nacked});
  end
  task automatic cmd(input logic rd, input logic pl, input logic [2:0] dev,
                     input logic [13:0] a, input logic [7:0] n,
                     input logic nk);
    exp_nk.push_back(nk);
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_poll = pl;
    cmd_dev = dev;
    cmd_addr = a;
    cmd_len = n;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    @(negedge sys_clk);
    while (done !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask
  // valid stays up between words: each word is offered only once wr_ready is seen high
  task automatic feed(input int s, input int n);
    for (int i = s; i < s + n; i++) begin
      while (wr_ready !== 1'b1) @(negedge sys_clk);
      wr_valid = 1'b1;
      wr_data = pg[i];
      @(negedge sys_clk);
    end
    wr_valid = 1'b0;
  endtask
  task automatic do_wr(input logic [13:0] a, input int n, input int s,
                       input logic keep);
    fork
      cmd(1'b0, 1'b0, cs, a, 8'(n), 1'b0);
      feed(s, n - s);
    join
    if (keep)
      for (int i = 0; i < n; i++) ref_mem[{a[13:6], a[5:0] + 6'(i)}] = pg[i];
  endtask
  task automatic do_rd(input logic [13:0] a, input int n);
    for (int i = 0; i < n; i++) exp_rd.push_back(ref_mem[a + 14'(i)]);
    cmd(1'b1, 1'b0, cs, a, 8'(n), 1'b0);
  endtask
  task automatic do_poll;
    cmd(1'b0, 1'b1, cs, 14'h0, 8'h0, 1'b0);
    check("busy", 8'h0, {7'h0, busy});
  endtask
  task automatic new_page;
    for (int i = 0; i < 66; i++) pg[i] = 8'($random(seed));
  endtask
  initial begin
    seed = 32'hb7ae1798;
    {sys_rst, busy_seen, write_protect, cmd_valid, wr_valid} = 5'h10;
    {cmd_read, cmd_poll, cmd_dev, cmd_addr, cmd_len, wr_data} = 0;
    cycles = 0;
    err_count = 0;
    samples_checked = 0;
    cs = 3'($random(seed));
    addr = 14'($random(seed));
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    new_page();
    do_wr(addr, 1, 0, 1'b1);
    check("busy seen", 8'h1, {7'h0, busy_seen});
    do_poll();
    do_rd(addr, 1);
    // protected write: acked, array untouched, no cycle
    write_protect = 1'b1;
    busy_seen = 1'b0;
    new_page();
    do_wr(addr, 1, 0, 1'b0);
    write_protect = 1'b0;
    check("busy seen", 8'h0, {7'h0, busy_seen});
    do_rd(addr, 1);
    // protect raised only after the stop must not cancel the cycle
    new_page();
    do_wr(addr, 1, 0, 1'b1);
    write_protect = 1'b1;
    do_poll();
    write_protect = 1'b0;
    do_rd(addr, 1);
    // page write of 66 bytes from near page end: wraps and overwrites
    new_page();
    addr[5:0] = 6'h3c;
    feed(0, 32);
    check("wr_ready", 8'h0, {7'h0, wr_ready});
    do_wr(addr, 66, 32, 1'b1);
    do_poll();
    do_rd({addr[13:6], 6'h0}, 64);
    // address-only commands to every select code
    for (int d = 0; d < 8; d++) begin
      busy_seen = 1'b0;
      cmd(1'b0, 1'b0, 3'(d), addr, 8'h0, 3'(d) != cs);
      check("busy seen", 8'h0, {7'h0, busy_seen});
    end
    stop_test();
  end
endmodule

//--- bench/eeps_properties.sv
// concurrent checks on the two-wire link between master and eeprom
// assumes it sits beside the link interface, quarter of 8 cycles
`timescale 1ns/1ns
module eeps_properties #(
  parameter int TWC_CYC = 200
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic busy
);
  // start must lead to a low scl within five quarters, just over one bit time
  localparam int HI_MAX = 40;
  int wc_cnt;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wc_cnt <= 0;
    end else begin
      wc_cnt <= busy ? wc_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_slave_moves_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("eeprom end moved sda while scl high");
  a_data_edge_apart: assert property ($changed(scl) |-> $stable(sda))
    else $error("sda moved on an scl edge");
  a_ack_stays_low: assert property (
    scl && sda_s_oe |=> sda_s_oe || !scl)
    else $error("eeprom released sda inside scl high");
  a_start_then_low: assert property (
    scl && $past(scl) && $rose(sda_m_oe) |-> ##[1:HI_MAX] !scl)
    else $error("no scl low after start");
  a_stop_keeps_idle: assert property (
    scl && $past(scl) && $fell(sda_m_oe) |=> (scl && sda) [*4])
    else $error("bus not idle after stop");
  a_busy_silent: assert property (busy |-> !sda_s_oe)
    else $error("eeprom drove sda during write cycle");
  a_busy_after_stop: assert property ($rose(busy) |-> scl && sda)
    else $error("write cycle began without stop");
  a_cycle_length: assert property (
    $fell(busy) |-> wc_cnt >= TWC_CYC - 1 && wc_cnt <= TWC_CYC + 1)
    else $error("write cycle length wrong");
endmodule

//--- pkg/eeps_consts.svh
// constants of the serial eeprom link: framing, timing, sizes
// assumes a 20 ns system clock on both ends
`ifndef EEPS_CONSTS_SVH
`define EEPS_CONSTS_SVH
// device type code, value arbitrary
`define EEPS_TYPE_CODE 4'h5
`define EEPS_ADDR_W 14
`define EEPS_PAGE_BYTES 64
`define EEPS_LAST_BIT 4'h7
`define EEPS_ACK_BIT 4'h8
`define EEPS_CLK_NS 20
`define EEPS_TWC_MS 5
`define EEPS_TWC_CYC (`EEPS_TWC_MS * 1000000 / `EEPS_CLK_NS)
`define EEPS_SCL_QTR_NS 2500
`define EEPS_SCL_QTR_CYC \
  ((`EEPS_SCL_QTR_NS + `EEPS_CLK_NS - 1) / `EEPS_CLK_NS)
`define EEPS_FIFO_DEPTH 32
`endif

//--- pkg/eeps_if.sv
// two-wire link between the bus master end and the eeprom end
// sda is open drain: a driver pulls low while its enable is high
`timescale 1ns/1ns
interface eeps_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  wire scl;
  wire sda;
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));
  modport master(output scl_out, scl_oe, sda_m_out, sda_m_oe,
                 input scl, sda);
  modport slave(output sda_s_out, sda_s_oe, input scl, sda);
endinterface

//--- pkg/eeps_pkg.sv
// state types for each end of the link and the master end's byte-kind type
// assumes nothing beyond the constants header
package eeps_pkg;
  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_CTRL = 7'h02,
    DS_ADRH = 7'h04,
    DS_ADRL = 7'h08,
    DS_WDATA = 7'h10,
    DS_RDATA = 7'h20,
    DS_IGNORE = 7'h40
  } eeps_dstate_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_START = 4'h2,
    HS_BYTE = 4'h4,
    HS_STOP = 4'h8
  } eeps_hstate_t;
  typedef enum logic [5:0] {
    HK_CTRLW = 6'h01,
    HK_ADRH = 6'h02,
    HK_ADRL = 6'h04,
    HK_DATAW = 6'h08,
    HK_CTRLR = 6'h10,
    HK_DATAR = 6'h20
  } eeps_kind_t;
endpackage

//--- rtl/eeps_master.sv
// bus master end: fifo-fed writes, random reads, ack polling
// assumes the eeprom end answers on sda within a quarter scl period
`timescale 1ns/1ns
`include "eeps_consts.svh"
module eeps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `EEPS_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_chk
    $error("eeps_fifo: depth must be a power of two");
  end
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr;
  logic [AW:0] rd;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (wr ^ rd) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr != rd;
  assign out_data = store[rd[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (push)
      store[wr[AW-1:0]] <= in_data;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr <= '0;
      rd <= '0;
    end else begin
      if (push)
        wr <= wr + 1'b1;
      if (pop)
        rd <= rd + 1'b1;
    end
  end
endmodule

module eeps_master #(
  parameter int QTR_CYC = `EEPS_SCL_QTR_CYC,
  parameter int FIFO_DEPTH = `EEPS_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_poll,
  input wire logic [2:0] cmd_dev,
  input wire logic [13:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nacked,
  eeps_if.master bus
);
  localparam int QW = $clog2(QTR_CYC + 1);
  if (QTR_CYC < 8) begin : g_chk
    $error("eeps_master: quarter period too short for the far end");
  end

  eeps_pkg::eeps_hstate_t state;
  eeps_pkg::eeps_kind_t kind;
  logic [QW-1:0] qcnt;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [7:0] left;
  logic rd_op;
  logic poll;
  logic [2:0] dev;
  logic [13:0] addr;
  logic nack_seen;
  logic ackbit;
  logic scl_q;
  logic sda_q;
  logic [1:0] sda_s;
  logic f_valid;
  logic [7:0] f_data;

  function automatic logic [7:0] next_byte(eeps_pkg::eeps_kind_t k,
      logic [2:0] d, logic [13:0] a, logic [7:0] fd);
    case (k)
      eeps_pkg::HK_CTRLW: next_byte = {`EEPS_TYPE_CODE, d, 1'b0};
      eeps_pkg::HK_CTRLR: next_byte = {`EEPS_TYPE_CODE, d, 1'b1};
      eeps_pkg::HK_ADRH: next_byte = {2'h0, a[13:8]};
      eeps_pkg::HK_ADRL: next_byte = a[7:0];
      eeps_pkg::HK_DATAW: next_byte = fd;
      default: next_byte = 8'hff;
    endcase
  endfunction

  wire tick = qcnt == QW'(QTR_CYC - 1);
  wire rx = kind == eeps_pkg::HK_DATAR;
  wire [7:0] nb = next_byte(kind, dev, addr, f_data);
  // an empty fifo stalls the byte with scl held low
  wire need = state == eeps_pkg::HS_BYTE && bitn == 4'h0 &&
              ph == 2'h0 && kind == eeps_pkg::HK_DATAW;
  wire stall = need & ~f_valid;
  wire f_pop = need & f_valid & tick;
  wire last = left == 8'h01;

  eeps_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  assign bus.scl_out = scl_q;
  assign bus.scl_oe = 1'b1;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe = sda_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= eeps_pkg::HS_IDLE;
      kind <= eeps_pkg::HK_CTRLW;
      qcnt <= '0;
      ph <= 2'h0;
      bitn <= 4'h0;
      sh <= 8'h00;
      left <= 8'h00;
      {rd_op, poll, dev, addr} <= '0;
      {nack_seen, ackbit} <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b0;
      sda_s <= 2'h3;
      cmd_ready <= 1'b0;
      {rd_valid, done, nacked} <= 3'h0;
      rd_data <= 8'h00;
    end else begin
      sda_s <= {sda_s[0], bus.sda};
      rd_valid <= 1'b0;
      done <= 1'b0;
      qcnt <= tick ? '0 : qcnt + 1'b1;
      if (state == eeps_pkg::HS_IDLE) begin
        cmd_ready <= 1'b1;
        qcnt <= '0;
        if (cmd_valid && cmd_ready) begin
          cmd_ready <= 1'b0;
          {rd_op, poll, dev, addr} <= {cmd_read, cmd_poll, cmd_dev,
                                       cmd_addr};
          left <= cmd_len;
          kind <= eeps_pkg::HK_CTRLW;
          nack_seen <= 1'b0;
          state <= eeps_pkg::HS_START;
        end
      end else if (tick && !stall) begin
        ph <= ph + 2'h1;
        case (state)
          eeps_pkg::HS_START: begin
            // only spot where sda falls with scl high
            case (ph)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1; // RL1
              default: begin
                scl_q <= 1'b0;
                bitn <= 4'h0;
                state <= eeps_pkg::HS_BYTE;
              end
            endcase
          end
          eeps_pkg::HS_BYTE: begin
            case (ph)
              2'h0: begin
                // sda moves only while scl is low
                if (bitn == `EEPS_ACK_BIT)
                  sda_q <= rx & ~last; // RL5 RL8
                else if (bitn == 4'h0) begin
                  sh <= nb;
                  sda_q <= ~rx & ~nb[7];
                end else
                  sda_q <= ~rx & ~sh[7]; // RL3
              end
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bitn == `EEPS_ACK_BIT)
                  ackbit <= sda_s[1];
                else
                  sh <= {sh[6:0], sda_s[1]};
              end
              default: begin
                scl_q <= 1'b0;
                bitn <= bitn + 4'h1;
                if (bitn == `EEPS_ACK_BIT) begin
                  bitn <= 4'h0;
                  if (!rx && ackbit) begin
                    nack_seen <= 1'b1;
                    state <= eeps_pkg::HS_STOP;
                  end else begin
                    case (kind)
                      eeps_pkg::HK_CTRLW: begin
                        kind <= eeps_pkg::HK_ADRH;
                        if (poll)
                          state <= eeps_pkg::HS_STOP;
                      end
                      eeps_pkg::HK_ADRH: kind <= eeps_pkg::HK_ADRL;
                      eeps_pkg::HK_ADRL: begin
                        kind <= rd_op ? eeps_pkg::HK_CTRLR
                                      : eeps_pkg::HK_DATAW;
                        if (rd_op)
                          state <= eeps_pkg::HS_START;
                        else if (left == 8'h00)
                          state <= eeps_pkg::HS_STOP;
                      end
                      eeps_pkg::HK_CTRLR: kind <= eeps_pkg::HK_DATAR;
                      default: begin
                        left <= left - 8'h01; // RL4
                        if (rx) begin
                          rd_valid <= 1'b1;
                          rd_data <= sh;
                        end
                        if (last || left == 8'h00)
                          state <= eeps_pkg::HS_STOP;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          eeps_pkg::HS_STOP: begin
            case (ph)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0; // RL2
              default: begin
                if (poll && nack_seen) begin
                  nack_seen <= 1'b0;
                  kind <= eeps_pkg::HK_CTRLW;
                  state <= eeps_pkg::HS_START; // RL20
                end else begin
                  done <= 1'b1;
                  nacked <= nack_seen;
                  state <= eeps_pkg::HS_IDLE;
                end
              end
            endcase
          end
          default: state <= eeps_pkg::HS_IDLE;
        endcase
      end
    end
  end
endmodule

//--- rtl/eeps_slave.sv
// eeprom end of the two-wire link: framing, addressing, page write,
// write cycle with ack withholding, and simple reads of its own array
// assumes scl and sda come from another domain and are resampled here
`timescale 1ns/1ns
`include "eeps_consts.svh"
// Overview of operation
// (RL1) sda fall with scl high is start
// (RL2) sda rise with scl high is stop
// (RL3) data sampled on scl rise, one bit
// (RL4) master chooses byte count per transfer
// (RL5) receiver acks every byte on ninth pulse
// (RL6) no acks at all during write cycle
// (RL7) ack holds sda low through high phase
// (RL8) master nack ends read, sda released
// (RL9) control byte: type, selects, rw last
// (RL10) ack control only on type and selects
// (RL11) rw one reads, zero writes
// (RL12) two address bytes, high first, 14 bits
// (RL13) ack address and data, stop starts write
// (RL14) pointer ends one past last written
// (RL15) buffer up to 64 bytes, commit after stop
// (RL16) only six low pointer bits increment
// (RL17) over 64 bytes wraps and overwrites
// (RL18) protected write acked, no cycle started
// (RL19) protect input sampled at stop
// (RL20) master polls with control byte until ack
// (RL21) reads wrap inside own array only
// (RL22) repeated start keeps pointer, no write
// (RL23) mismatch releases sda until next start
// (RL24) start or stop mid-byte abandons, no write
module eeps_slave #(
  parameter int ADDR_W = `EEPS_ADDR_W,
  parameter int PAGE_BYTES = `EEPS_PAGE_BYTES,
  parameter int TWC_CYC = `EEPS_TWC_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chip_select_bit_two,
  input wire logic chip_select_bit_one,
  input wire logic chip_select_bit_zero,
  input wire logic write_protect,
  output logic busy,
  eeps_if.slave bus
);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int TW = $clog2(TWC_CYC + 1);

  if (ADDR_W > 16 || ADDR_W <= PW || PAGE_BYTES != (1 << PW) ||
      TWC_CYC < PAGE_BYTES + 1) begin : g_chk
    $error("eeps_slave: unsupported parameters");
  end

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] wp_s;
  logic [2:0] cs_a;
  logic [2:0] cs_b;
  eeps_pkg::eeps_dstate_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [ADDR_W-1:0] ptr;
  logic sda_drive;
  logic got_data;
  logic [PAGE_BYTES-1:0] valid;
  logic [TW-1:0] timer;
  logic [PW:0] cidx;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [1 << ADDR_W];

  // stage 0 feeds only stage 1; stage 2 is the edge reference
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire scl_high = scl_s[1] & scl_s[2];
  wire start_det = scl_high & ~sda_s[1] & sda_s[2]; // RL1
  wire stop_det = scl_high & sda_s[1] & ~sda_s[2]; // RL2
  wire active = (state != eeps_pkg::DS_IDLE) &&
                (state != eeps_pkg::DS_IGNORE);
  wire byte_end = active & scl_fall & (cnt == `EEPS_LAST_BIT);
  wire ack_end = active & scl_fall & (cnt == `EEPS_ACK_BIT);
  wire ctrl_hit = (shreg[7:4] == `EEPS_TYPE_CODE) &&
                  (shreg[3:1] == cs_b); // RL9 RL10
  // stop on a byte boundary leaves cnt at zero
  wire commit = stop_det & (state == eeps_pkg::DS_WDATA) & got_data &
                (cnt == 4'h0) & ~wp_s[1]; // RL13 RL18 RL19 RL24
  wire [7:0] rd_byte = mem[ptr];
  wire [ADDR_W-1:0] cw_addr = {ptr[ADDR_W-1:PW], cidx[PW-1:0]};

  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe = sda_drive;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      wp_s <= 2'h0;
      cs_a <= 3'h0;
      cs_b <= 3'h0;
    end else begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
      wp_s <= {wp_s[0], write_protect};
      cs_a <= {chip_select_bit_two, chip_select_bit_one,
               chip_select_bit_zero};
      cs_b <= cs_a;
    end
  end

  // write cycle: copy buffered bytes, then wait out the cycle time
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      timer <= '0;
      cidx <= '0;
    end else if (commit) begin
      busy <= 1'b1; // RL15
      timer <= '0;
      cidx <= '0;
    end else if (busy) begin
      timer <= timer + 1'b1;
      if (!cidx[PW])
        cidx <= cidx + 1'b1;
      if (timer == TW'(TWC_CYC - 1))
        busy <= 1'b0;
    end
  end

  // arrays carry no reset; only bytes seen since the address count
  always_ff @(posedge sys_clk) begin
    if (byte_end && state == eeps_pkg::DS_WDATA)
      pbuf[ptr[PW-1:0]] <= shreg; // RL17
    if (busy && !cidx[PW] && valid[cidx[PW-1:0]])
      mem[cw_addr] <= pbuf[cidx[PW-1:0]]; // RL15
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= eeps_pkg::DS_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= '0;
      sda_drive <= 1'b0;
      got_data <= 1'b0;
      valid <= '0;
    end else if (start_det) begin
      // pointer kept; an unfinished write is simply dropped
      state <= eeps_pkg::DS_CTRL; // RL22 RL24
      // the scl fall that closes the start carries no bit: wraps to zero
      cnt <= 4'hf;
      sda_drive <= 1'b0;
      got_data <= 1'b0;
    end else if (stop_det) begin
      state <= eeps_pkg::DS_IDLE; // RL24
      cnt <= 4'h0;
      sda_drive <= 1'b0;
    end else if (active) begin
      if (scl_rise) begin
        if (cnt < `EEPS_ACK_BIT)
          shreg <= {shreg[6:0], sda_s[1]}; // RL3
        else if (state == eeps_pkg::DS_RDATA && sda_s[1])
          state <= eeps_pkg::DS_IGNORE; // RL8
      end
      if (scl_fall)
        cnt <= (cnt == `EEPS_ACK_BIT) ? 4'h0 : cnt + 4'h1;
      if (byte_end) begin
        case (state)
          eeps_pkg::DS_CTRL: begin
            if (ctrl_hit && !busy) begin
              sda_drive <= 1'b1; // RL5 RL7
              state <= shreg[0] ? eeps_pkg::DS_RDATA
                                : eeps_pkg::DS_ADRH; // RL11
            end else begin
              state <= eeps_pkg::DS_IGNORE; // RL6 RL23
            end
          end
          eeps_pkg::DS_ADRH: begin
            ptr[ADDR_W-1:8] <= shreg[ADDR_W-9:0]; // RL12
            sda_drive <= 1'b1;
            state <= eeps_pkg::DS_ADRL;
          end
          eeps_pkg::DS_ADRL: begin
            ptr[7:0] <= shreg;
            valid <= '0;
            sda_drive <= 1'b1; // RL13
            state <= eeps_pkg::DS_WDATA;
          end
          eeps_pkg::DS_WDATA: begin
            valid[ptr[PW-1:0]] <= 1'b1;
            ptr[PW-1:0] <= ptr[PW-1:0] + 1'b1; // RL14 RL16 RL17
            got_data <= 1'b1;
            sda_drive <= 1'b1; // RL4
          end
          eeps_pkg::DS_RDATA: sda_drive <= 1'b0;
          default: state <= eeps_pkg::DS_IGNORE;
        endcase
      end else if (ack_end) begin
        sda_drive <= 1'b0;
        if (state == eeps_pkg::DS_RDATA) begin
          tx <= rd_byte;
          sda_drive <= ~rd_byte[7];
          ptr <= ptr + 1'b1; // RL21
        end
      end else if (scl_fall && state == eeps_pkg::DS_RDATA) begin
        sda_drive <= ~tx[6];
        tx <= {tx[6:0], 1'b0};
      end
    end
  end
endmodule
